// File: hw/dsc_pkg.sv
`default_nettype none

// ==========================================================
// Shared constants of the serial control port
package dsc_pkg;
    // Serial word layout
    localparam int WORD_W = 16;
    localparam int CNT_W = 4;
    localparam logic [3:0] LAST_BIT = 4'hf;
    localparam int ADDR_HI = 15;
    localparam int ADDR_LO = 14;
    localparam int PAYLOAD_W = 14;

    // Destination codes in the top two bits
    localparam logic [1:0] DEST_CONTROL = 2'h0;
    localparam logic [1:0] DEST_FREQUENCY_WORD_ZERO = 2'h1;
    localparam logic [1:0] DEST_FREQUENCY_WORD_ONE = 2'h2;
    localparam logic [1:0] DEST_PHASE = 2'h3;
    localparam int PHASE_SEL_BIT = 13;

    // Frequency and phase register widths
    localparam int FREQ_W = 28;
    localparam int PHASE_W = 12;

    // Control register fields
    localparam int CTL_FULL_WORD_LOAD = 13;
    localparam int CTL_HALF_HIGH = 12;
    localparam int CTL_FREQ_REG_CHOICE = 11;
    localparam int CTL_PHASE_REG_CHOICE = 10;
    localparam int CTL_PIN_OR_SOFTWARE = 9;
    localparam int CTL_CORE_RESET = 8;
    localparam int CTL_CLOCK_DISABLE = 7;
    localparam int CTL_DAC_POWER_DOWN = 6;
    localparam int CTL_OUTPUT_BIT_ENABLE = 5;
    localparam int CTL_SIGN_OUTPUT_ENABLE = 4;
    localparam int CTL_DIVIDE_BY_TWO = 3;
    localparam int CTL_MODE = 1;
    localparam logic [15:0] CTL_RESET_VALUE = 16'h0000;

    // Pin synchroniser bit order
    localparam int PIN_W = 4;
    localparam int PIN_FREQ = 0;
    localparam int PIN_PHASE = 1;
    localparam int PIN_RESET = 2;
    localparam int PIN_SLEEP = 3;

    // Latency, in master clock cycles
    localparam int LATENCY_CYCLES = 8;
    localparam int SYNC_STAGES = 2;
    localparam int PIPE_STAGES = LATENCY_CYCLES - SYNC_STAGES;

    // Width of the delayed core vector
    localparam int PIPE_W = FREQ_W + PHASE_W + 7;
endpackage

`default_nettype wire

// File: hw/dsc_serial_rx.sv
`default_nettype none

// ==========================================================
// Link side shift register, clocked by the serial clock
module dsc_serial_rx (
    input wire logic i_sclk_link,
    input wire logic i_rst,
    input wire logic i_frame_select_n,
    input wire logic i_serial_data,
    output logic [15:0] o_word,
    output logic o_word_toggle
);

    logic [dsc_pkg::CNT_W-1:0] bit_count;
    logic [dsc_pkg::WORD_W-2:0] shift;

    // Frame high clears the count, so a short frame is lost
    always_ff @(negedge i_sclk_link or posedge i_frame_select_n or posedge i_rst) begin
        if (i_rst || i_frame_select_n) begin
            bit_count <= '0;
            shift <= '0;
        end else begin
            shift <= {shift[dsc_pkg::WORD_W-3:0], i_serial_data};
            bit_count <= bit_count + 4'h1;
        end
    end

    // Finished word held until the next one; toggle marks it
    always_ff @(negedge i_sclk_link or posedge i_rst) begin
        if (i_rst) begin
            o_word <= 16'h0000;
            o_word_toggle <= 1'b0;
        end else if (!i_frame_select_n && bit_count == dsc_pkg::LAST_BIT) begin
            o_word <= {shift, i_serial_data};
            o_word_toggle <= ~o_word_toggle;
        end
    end

endmodule

`default_nettype wire

// File: hw/dsc_control_port.sv
`default_nettype none

// Summary of operation
// - Each transfer is one 16-bit word
// - Bits accepted only while frame select low
// - One bit per falling serial clock edge
// - Long frames carry back-to-back words
// - Select pins act after eight cycles
// - Register loads reach output after eight cycles
// - Reset and sleep pins pass pipeline latency
// - Sixteen-bit control register written serially
// - Control bits except mode sampled into core
// - Top bits 00 address control register
// - Comparator needs sign and output-bit enables
// - Full-word load takes two writes, low first
// - Half-word writes follow the half-select bit
// - Frequency choice bit picks accumulator register
// - Pin-or-software bit routes selects, reset, sleep

// ==========================================================
// Serial control port and control word front end
module dsc_control_port (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic i_sclk_link,
    input wire logic i_frame_select_n,
    input wire logic i_serial_data,
    input wire logic i_freq_choice_pin,
    input wire logic i_phase_choice_pin,
    input wire logic i_reset_pin,
    input wire logic i_sleep_pin,
    output logic [27:0] o_freq_word,
    output logic [11:0] o_phase_word,
    output logic o_core_reset,
    output logic o_dac_power_down,
    output logic o_clock_disable,
    output logic o_comparator_enable,
    output logic o_output_bit_enable,
    output logic o_sign_output_enable,
    output logic o_divide_by_two,
    output logic o_mode,
    output logic [15:0] o_control_word,
    output logic o_word_strobe
);

    // ==========================================================
    // Link domain receiver

    logic [15:0] link_word;
    logic link_toggle;

    // Host keeps the frame low through each sixteenth edge
    dsc_serial_rx u_rx (
        .i_sclk_link(i_sclk_link),
        .i_rst(i_rst),
        .i_frame_select_n(i_frame_select_n),
        .i_serial_data(i_serial_data),
        .o_word(link_word),
        .o_word_toggle(link_toggle)
    );

    // ==========================================================
    // Word crossing into the system clock

    logic tog_s1;
    logic tog_s2;
    logic tog_seen;
    logic word_new;

    // Toggle crossing; the held word is stable for 16 serial bits
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_seen <= 1'b0;
        end else if (i_clk_en) begin
            tog_s1 <= link_toggle;
            tog_s2 <= tog_s1;
            tog_seen <= tog_s2;
        end
    end

    assign word_new = i_clk_en && (tog_s2 != tog_seen);

    // ==========================================================
    // Pin synchronisers

    logic [dsc_pkg::PIN_W-1:0] pin_raw;
    logic [dsc_pkg::PIN_W-1:0] pin_s1;
    logic [dsc_pkg::PIN_W-1:0] pin_s2;

    assign pin_raw[dsc_pkg::PIN_FREQ] = i_freq_choice_pin;
    assign pin_raw[dsc_pkg::PIN_PHASE] = i_phase_choice_pin;
    assign pin_raw[dsc_pkg::PIN_RESET] = i_reset_pin;
    assign pin_raw[dsc_pkg::PIN_SLEEP] = i_sleep_pin;

    // Two stages; a late pin edge costs one more cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else if (i_clk_en) begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
        end
    end

    // ==========================================================
    // Register file and write decode

    logic [15:0] ctrl;
    logic [dsc_pkg::FREQ_W-1:0] frequency_word_zero;
    logic [dsc_pkg::FREQ_W-1:0] frequency_word_one;
    logic [dsc_pkg::PHASE_W-1:0] phase0;
    logic [dsc_pkg::PHASE_W-1:0] phase1;
    logic pend_valid;
    logic [1:0] pend_dest;
    logic [dsc_pkg::PAYLOAD_W-1:0] pend_low;
    logic [1:0] dest;
    logic [dsc_pkg::PAYLOAD_W-1:0] payload;
    logic is_freq;
    logic pair_done;
    logic [dsc_pkg::FREQ_W-1:0] next_freq;
    logic [dsc_pkg::FREQ_W-1:0] cur_freq;

    assign dest = link_word[dsc_pkg::ADDR_HI:dsc_pkg::ADDR_LO];
    assign payload = link_word[dsc_pkg::PAYLOAD_W-1:0];
    assign is_freq = (dest == dsc_pkg::DEST_FREQUENCY_WORD_ZERO) || (dest == dsc_pkg::DEST_FREQUENCY_WORD_ONE);
    assign pair_done = pend_valid && (pend_dest == dest);
    assign cur_freq = (dest == dsc_pkg::DEST_FREQUENCY_WORD_ONE) ? frequency_word_one : frequency_word_zero;

    // New frequency value for the addressed register
    always_comb begin
        next_freq = cur_freq;
        if (ctrl[dsc_pkg::CTL_FULL_WORD_LOAD]) begin
            next_freq = {payload, pend_low};
        end else if (ctrl[dsc_pkg::CTL_HALF_HIGH]) begin
            next_freq = {payload, cur_freq[dsc_pkg::PAYLOAD_W-1:0]};
        end else begin
            next_freq = {cur_freq[dsc_pkg::FREQ_W-1:dsc_pkg::PAYLOAD_W], payload};
        end
    end

    // Control register; top bits 00 route the word here
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ctrl <= dsc_pkg::CTL_RESET_VALUE;
        end else if (word_new && dest == dsc_pkg::DEST_CONTROL) begin
            ctrl <= {2'h0, payload};
        end
    end

    // Pending low half of a full-word pair
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pend_valid <= 1'b0;
            pend_dest <= 2'h0;
            pend_low <= '0;
        end else if (word_new) begin
            if (is_freq && ctrl[dsc_pkg::CTL_FULL_WORD_LOAD] && !pair_done) begin
                pend_valid <= 1'b1;
                pend_dest <= dest;
                pend_low <= payload;
            end else begin
                pend_valid <= 1'b0;
            end
        end
    end

    // Frequency registers; a pair commits only on its second half
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            frequency_word_zero <= '0;
            frequency_word_one <= '0;
        end else if (word_new && is_freq) begin
            if (!ctrl[dsc_pkg::CTL_FULL_WORD_LOAD] || pair_done) begin
                if (dest == dsc_pkg::DEST_FREQUENCY_WORD_ONE) begin
                    frequency_word_one <= next_freq;
                end else begin
                    frequency_word_zero <= next_freq;
                end
            end
        end
    end

    // Phase registers; bit 13 picks which one
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            phase0 <= '0;
            phase1 <= '0;
        end else if (word_new && dest == dsc_pkg::DEST_PHASE) begin
            if (link_word[dsc_pkg::PHASE_SEL_BIT]) begin
                phase1 <= payload[dsc_pkg::PHASE_W-1:0];
            end else begin
                phase0 <= payload[dsc_pkg::PHASE_W-1:0];
            end
        end
    end

    // Commit marker, one cycle per accepted word
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_word_strobe <= 1'b0;
        end else if (i_clk_en) begin
            o_word_strobe <= word_new;
        end
    end

    // ==========================================================
    // Core sampling of registers

    localparam int CORE_W = 2 * dsc_pkg::FREQ_W + 2 * dsc_pkg::PHASE_W + dsc_pkg::PAYLOAD_W;

    logic [CORE_W-1:0] core_src;
    logic [CORE_W-1:0] core_a;
    logic [CORE_W-1:0] core_b;

    assign core_src = {frequency_word_zero, frequency_word_one, phase0, phase1, ctrl[dsc_pkg::PAYLOAD_W-1:0]};

    // Two stages so loads match the pin path latency
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            core_a <= '0;
            core_b <= '0;
        end else if (i_clk_en) begin
            core_a <= core_src;
            core_b <= core_a;
        end
    end

    logic [dsc_pkg::FREQ_W-1:0] c_frequency_word_zero;
    logic [dsc_pkg::FREQ_W-1:0] c_frequency_word_one;
    logic [dsc_pkg::PHASE_W-1:0] c_phase0;
    logic [dsc_pkg::PHASE_W-1:0] c_phase1;
    logic [dsc_pkg::PAYLOAD_W-1:0] c_ctrl;

    assign {c_frequency_word_zero, c_frequency_word_one, c_phase0, c_phase1, c_ctrl} = core_b;

    // ==========================================================
    // Source selection, pins or control bits

    logic use_pins;
    logic sel_freq;
    logic sel_phase;
    logic sel_reset;
    logic sel_sleep;
    logic sel_comp;
    logic [dsc_pkg::PIPE_W-1:0] sel_vec;

    assign use_pins = c_ctrl[dsc_pkg::CTL_PIN_OR_SOFTWARE];

    // Pin mode hands selects, reset and power-down to the pins
    always_comb begin
        if (use_pins) begin
            sel_freq = pin_s2[dsc_pkg::PIN_FREQ];
            sel_phase = pin_s2[dsc_pkg::PIN_PHASE];
            sel_reset = pin_s2[dsc_pkg::PIN_RESET];
            sel_sleep = pin_s2[dsc_pkg::PIN_SLEEP];
        end else begin
            sel_freq = c_ctrl[dsc_pkg::CTL_FREQ_REG_CHOICE];
            sel_phase = c_ctrl[dsc_pkg::CTL_PHASE_REG_CHOICE];
            sel_reset = c_ctrl[dsc_pkg::CTL_CORE_RESET];
            sel_sleep = c_ctrl[dsc_pkg::CTL_DAC_POWER_DOWN];
        end
    end

    // Both enables needed; either alone leaves it off
    assign sel_comp = c_ctrl[dsc_pkg::CTL_SIGN_OUTPUT_ENABLE] & c_ctrl[dsc_pkg::CTL_OUTPUT_BIT_ENABLE];

    assign sel_vec = {
        sel_freq ? c_frequency_word_one : c_frequency_word_zero,
        sel_phase ? c_phase1 : c_phase0,
        sel_reset,
        sel_sleep,
        c_ctrl[dsc_pkg::CTL_CLOCK_DISABLE],
        sel_comp,
        c_ctrl[dsc_pkg::CTL_OUTPUT_BIT_ENABLE],
        c_ctrl[dsc_pkg::CTL_SIGN_OUTPUT_ENABLE],
        c_ctrl[dsc_pkg::CTL_DIVIDE_BY_TWO]
    };

    // ==========================================================
    // Latency pipeline

    logic [dsc_pkg::PIPE_W-1:0] pipe [dsc_pkg::PIPE_STAGES];

    // Six stages after the two sampling stages give eight cycles
    genvar g;
    generate
        for (g = 0; g < dsc_pkg::PIPE_STAGES; g++) begin : g_pipe
            always_ff @(posedge i_clk_sys) begin
                if (i_rst) begin
                    pipe[g] <= '0;
                end else if (i_clk_en) begin
                    pipe[g] <= (g == 0) ? sel_vec : pipe[(g == 0) ? 0 : g - 1];
                end
            end
        end
    endgenerate

    // Outputs from the last pipeline stage
    assign {o_freq_word, o_phase_word, o_core_reset, o_dac_power_down, o_clock_disable,
            o_comparator_enable, o_output_bit_enable, o_sign_output_enable,
            o_divide_by_two} = pipe[dsc_pkg::PIPE_STAGES-1];

    // Mode bit bypasses the core sampling
    assign o_mode = ctrl[dsc_pkg::CTL_MODE];
    assign o_control_word = ctrl;

endmodule

`default_nettype wire

// File: dv/dsc_control_port_monitor.sv
`default_nettype none

// ==========================================================
// Port checker for the serial control port
module dsc_port_monitor (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_freq_choice_pin,
    input wire logic i_phase_choice_pin,
    input wire logic [27:0] o_freq_word,
    input wire logic [11:0] o_phase_word,
    input wire logic o_comparator_enable,
    input wire logic o_output_bit_enable,
    input wire logic o_sign_output_enable,
    input wire logic o_mode,
    input wire logic [15:0] o_control_word,
    input wire logic o_word_strobe
);
    logic [3:0] since;

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    // Cycles since the last legal cause of a word change, saturating
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || o_word_strobe || $changed(i_freq_choice_pin) || $changed(i_phase_choice_pin)) begin
            since <= 4'h0;
        end else if (since != 4'hf) begin
            since <= since + 4'h1;
        end
    end

    // ==========================================================
    // Assertions
    a_strobe_single: assert property (o_word_strobe |=> !o_word_strobe)
        else $error("word strobe longer than one cycle");
    a_top_bits_zero: assert property (o_control_word[15:14] == 2'h0)
        else $error("control word top bits set");
    a_mode_direct: assert property (o_mode == o_control_word[1])
        else $error("mode differs from control word");
    a_comparator_pair: assert property (o_comparator_enable == (o_output_bit_enable && o_sign_output_enable))
        else $error("comparator enable not the AND of its enables");
    a_enable_latency: assert property ($rose(o_control_word[5]) |-> ##[6:9] o_output_bit_enable)
        else $error("output bit enable late");
    a_sign_latency: assert property ($fell(o_control_word[4]) |-> ##[6:9] !o_sign_output_enable)
        else $error("sign output enable late");
    a_word_quiet: assert property ($changed(o_freq_word) || $changed(o_phase_word) |-> since <= 4'hc)
        else $error("word output changed without a cause");
    a_reset_clean: assert property ($fell(i_rst) |-> o_control_word == 16'h0 && !o_word_strobe)
        else $error("state not cleared by reset");
endmodule

bind dsc_control_port dsc_port_monitor i_mon (.i_clk_sys, .i_rst, .i_freq_choice_pin, .i_phase_choice_pin,
    .o_freq_word, .o_phase_word, .o_comparator_enable, .o_output_bit_enable, .o_sign_output_enable,
    .o_mode, .o_control_word, .o_word_strobe);

`default_nettype wire

// File: dv/dsc_host_model.sv
`default_nettype none

// ==========================================================
// Serial host: frame select, serial clock and data
module dsc_host_model (
    output logic o_sclk_link,
    output logic o_frame_select_n,
    output logic o_serial_data
);
    timeunit 1ns;
    timeprecision 100ps;

    // Clock idles high, so a falling frame never meets a low clock
    initial begin
        o_sclk_link = 1'b1;
        o_frame_select_n = 1'b1;
        o_serial_data = 1'b0;
    end

    // One frame, MSB first, 125 ns bit period; short counts abort
    task automatic send(input logic [15:0] w[$], input int nbits);
        int k;
        #3.7 o_frame_select_n = 1'b0;
        for (k = 0; k < nbits; k++) begin
            o_serial_data = w[k / 16][15 - k % 16];
            #31.25 o_sclk_link = 1'b0;
            #62.5 o_sclk_link = 1'b1;
            #31.25;
        end
        o_frame_select_n = 1'b1;
        // Released data line shows no stale bit
        o_serial_data = ~o_serial_data;
        #250;
    endtask
endmodule

`default_nettype wire

// File: dv/tb_dds_serial_control_port.sv
`default_nettype none

// ==========================================================
// Self-checking bench for the serial control port
module tb_dds_serial_control_port;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic i_clk_en = 1'b1;
    logic fpin = 1'b0, ppin = 1'b0, rpin = 1'b0, spin = 1'b0;
    logic sclk, frame_n, sdata, core_rst, dac_pd, clk_dis, cmp_en, obit, sign, div2, mode, strobe;
    logic [27:0] freq;
    logic [11:0] phase;
    logic [15:0] ctl;
    int err_total = 0;
    int checks = 0;
    int strobes = 0;

    // ==========================================================
    // Design, host and clock
    dsc_control_port i_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_clk_en(i_clk_en), .i_sclk_link(sclk),
        .i_frame_select_n(frame_n), .i_serial_data(sdata), .i_freq_choice_pin(fpin),
        .i_phase_choice_pin(ppin), .i_reset_pin(rpin), .i_sleep_pin(spin), .o_freq_word(freq),
        .o_phase_word(phase), .o_core_reset(core_rst), .o_dac_power_down(dac_pd), .o_clock_disable(clk_dis),
        .o_comparator_enable(cmp_en), .o_output_bit_enable(obit), .o_sign_output_enable(sign),
        .o_divide_by_two(div2), .o_mode(mode), .o_control_word(ctl), .o_word_strobe(strobe));
    dsc_host_model i_host (.o_sclk_link(sclk), .o_frame_select_n(frame_n), .o_serial_data(sdata));

    always #5 i_clk_sys = ~i_clk_sys;

    // Count committed words
    always @(posedge i_clk_sys) begin
        if (strobe === 1'b1) begin
            strobes++;
        end
    end

    // ==========================================================
    // Tasks
    task automatic chk(input string what, input logic [27:0] exp, input logic [27:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Frame, then settle past the output latency and count words
    task automatic wr(input logic [15:0] w[$], input int nbits);
        int s0;
        s0 = strobes;
        i_host.send(w, nbits);
        repeat (12) @(negedge i_clk_sys);
        chk("words", 28'(nbits / 16), 28'(strobes - s0));
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (12) @(negedge i_clk_sys);
        i_rst = 1'b0;
        repeat (3) @(negedge i_clk_sys);
        chk("control", 28'h0, 28'(ctl));
        chk("freq", 28'h0, freq);
        // Comparator on with both enables, off with one
        wr('{16'h0032}, 16);
        chk("control", 28'h0032, 28'(ctl));
        chk("compare", 28'h1, 28'(cmp_en));
        chk("mode", 28'h1, 28'(mode));
        wr('{16'h0020}, 16);
        chk("compare", 28'h0, 28'(cmp_en));
        chk("obit", 28'h1, 28'(obit));
        // Half writes in one long frame: high half, then low half
        wr('{16'h1000, 16'h7abc, 16'h0000, 16'h5234}, 64);
        chk("freq", {14'h3abc, 14'h1234}, freq);
        // Full word into register one, split over two frames
        wr('{16'h2800, 16'h8155}, 32);
        chk("freq", 28'h0, freq);
        wr('{16'haaaa}, 16);
        chk("freq", {14'h2aaa, 14'h0155}, freq);
        // Whole word kept, trailing partial word dropped
        wr('{16'h2000, 16'hffff}, 20);
        chk("control", 28'h2000, 28'(ctl));
        chk("freq", {14'h3abc, 14'h1234}, freq);
        // Pin control: selects, reset and sleep from the pins
        wr('{16'h0200, 16'hf5a5}, 32);
        chk("phase", 28'h0, 28'(phase));
        fpin = 1'b1;
        ppin = 1'b1;
        rpin = 1'b1;
        spin = 1'b1;
        repeat (7) @(negedge i_clk_sys);
        chk("freq", {14'h3abc, 14'h1234}, freq);
        repeat (2) @(negedge i_clk_sys);
        chk("freq", {14'h2aaa, 14'h0155}, freq);
        chk("phase", 28'h5a5, 28'(phase));
        chk("core reset", 28'h1, 28'(core_rst));
        chk("power down", 28'h1, 28'(dac_pd));
        rpin = 1'b0;
        spin = 1'b0;
        repeat (10) @(negedge i_clk_sys);
        chk("core reset", 28'h0, 28'(core_rst));
        chk("power down", 28'h0, 28'(dac_pd));
        conclude();
    end
endmodule

`default_nettype wire
